/* mcsq_host.sv */
// mcsq_host: management link host model, sends opcodes and collects answer bytes
// assumes the query block on the same clock; a byte is taken at an edge with valid and ready
`timescale 1ns/1ps
module mcsq_host
    import mcsq_pkg::*;
(
    input  wire logic       pclk,
    output mcsq_byte_t      cmd_out,
    input  wire mcsq_byte_t rsp_in,
    input  wire logic       rsp_last,
    output logic            rsp_ready
);
    logic [7:0] got [0:MCSQ_PAYLOAD_LEN-1];
    int         n_got;
    int         last_at;
    initial
    begin
        cmd_out   = '0;
        rsp_ready = 1'b0;
    end
    // high opcode byte first, then low byte, then the line is released
    task automatic run(input logic [15:0] op, input bit slow, input int lim);
        bit done;
        n_got   = 0;
        last_at = -1;
        done    = 0;
        cmd_out <= '{data: op[15:8], valid: 1'b1};
        @(posedge pclk);
        cmd_out <= '{data: op[7:0], valid: 1'b1};
        @(posedge pclk);
        cmd_out <= '{data: ~op[7:0], valid: 1'b0};
        for (int k = 0; k < lim && !done; k++)
        begin
            rsp_ready <= slow ? k[0] : 1'b1;
            @(posedge pclk);
            if (rsp_in.valid === 1'b1 && rsp_ready === 1'b1)
            begin
                if (n_got < MCSQ_PAYLOAD_LEN)
                    got[n_got] = rsp_in.data;
                if (rsp_last === 1'b1)
                begin
                    last_at = n_got;
                    done    = 1;
                end
                n_got++;
            end
        end
        rsp_ready <= 1'b0;
    endtask
endmodule

/* mcsq_pkg.sv */
// mcsq_pkg: constants, types and register map of the modulator status query block
// assumes an apb slave on pclk and a byte-wide command stream from the management link
package mcsq_pkg;

    localparam logic [15:0] MCSQ_OPCODE_QUERY = 16'h2400;

    // field byte offsets in the answer, back to back
    localparam int MCSQ_OFF_SPECTRUM  = 0;
    localparam int MCSQ_OFF_OPMODE    = 1;
    localparam int MCSQ_OFF_CLKSRC    = 2;
    localparam int MCSQ_OFF_CLKPOL    = 3;
    localparam int MCSQ_OFF_SENDTIM   = 4;
    localparam int MCSQ_OFF_FRAMING   = 5;
    localparam int MCSQ_OFF_DROPMODE  = 6;
    localparam int MCSQ_OFF_DROPMAP   = 7;
    localparam int MCSQ_DROPMAP_LEN   = 30;
    localparam int MCSQ_OFF_YELSEL    = 37;
    localparam int MCSQ_OFF_FORCED    = 38;
    localparam int MCSQ_OFF_TXMASK1   = 39;
    localparam int MCSQ_OFF_TXMASK2   = 40;
    localparam int MCSQ_OFF_CMNMASK2  = 41;
    localparam int MCSQ_OFF_SVC1_VOL  = 42;
    localparam int MCSQ_OFF_SVC2_VOL  = 43;
    localparam int MCSQ_OFF_IFTYPE    = 44;
    localparam int MCSQ_OFF_TERR_LB   = 45;
    localparam int MCSQ_OFF_BB_LB     = 46;
    localparam int MCSQ_PAYLOAD_LEN   = 47;

    // largest legal code of each enumerated field
    localparam logic [7:0] MCSQ_MAX_BOOL     = 8'h01;
    localparam logic [7:0] MCSQ_MAX_CLKSRC   = 8'h02;
    localparam logic [7:0] MCSQ_MAX_CLKPOL   = 8'h02;
    localparam logic [7:0] MCSQ_MAX_FRAMING  = 8'h03;
    localparam logic [7:0] MCSQ_MAX_DROPMODE = 8'h09;
    localparam logic [7:0] MCSQ_MAX_IFTYPE   = 8'h09;
    localparam logic signed [7:0] MCSQ_VOL_MIN = -8'sd20;
    localparam logic signed [7:0] MCSQ_VOL_MAX = 8'sd10;

    // spare bits forced to zero
    localparam logic [7:0] MCSQ_FORCED_USED  = 8'h3F;
    localparam logic [7:0] MCSQ_TXMASK2_USED = 8'h3F;
    localparam logic [7:0] MCSQ_CMN2_USED    = 8'h07;

    // apb register byte addresses
    localparam logic [7:0] MCSQ_REG_CTRL    = 8'h00;
    localparam logic [7:0] MCSQ_REG_STATUS  = 8'h04;
    localparam logic [7:0] MCSQ_REG_IRQ_ST  = 8'h08;
    localparam logic [7:0] MCSQ_REG_IRQ_MSK = 8'h0C;
    localparam logic [7:0] MCSQ_REG_CFG0    = 8'h10;
    localparam logic [7:0] MCSQ_REG_CFG1    = 8'h14;
    localparam logic [7:0] MCSQ_REG_CFG2    = 8'h18;
    localparam logic [7:0] MCSQ_REG_CFG3    = 8'h1C;
    localparam logic [7:0] MCSQ_REG_MAP     = 8'h40;
    localparam logic [7:0] MCSQ_REG_MAP_END = 8'hB4;

    // irq bits
    localparam int MCSQ_IRQ_QUERY = 0;
    localparam int MCSQ_IRQ_DONE  = 1;
    localparam int MCSQ_IRQ_BADOP = 2;
    localparam int MCSQ_IRQ_W     = 3;

    localparam logic [7:0] MCSQ_RST_BYTE = 8'h00;
    localparam logic [7:0] MCSQ_RST_MASK = 8'hFF;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } mcsq_byte_t;

    typedef enum logic [1:0] {MCSQ_IDLE, MCSQ_OPLO, MCSQ_SEND} mcsq_state_t;

endpackage

/* mcsq_query.sv */
// mcsq_query: command recogniser, configuration store and answer serialiser
// assumes command bytes from logic on pclk, one byte per valid, high opcode byte first
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module mcsq_query
    import mcsq_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire mcsq_byte_t  cmd_in,
    output mcsq_byte_t       rsp_out,
    output logic             rsp_last,
    input  wire logic        rsp_ready,
    output logic             irq
);

    logic [7:0]          cfg [0:MCSQ_PAYLOAD_LEN-1];
    logic [MCSQ_IRQ_W-1:0] irq_st;
    logic [MCSQ_IRQ_W-1:0] irq_msk;
    logic                enable;
    mcsq_state_t         state;
    logic [7:0]          op_hi;
    logic [5:0]          idx;
    logic                ev_query;
    logic                ev_done;
    logic                ev_bad;
    logic                wr;
    logic                rd;
    logic [7:0]          rsp_byte;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign pready  = 1'b1;

    // aligned word inside the drop map window
    function automatic logic in_map(input logic [7:0] a);
        in_map = (a[1:0] == 2'b00) && (a >= MCSQ_REG_MAP) && (a <= MCSQ_REG_MAP_END);
    endfunction

    // payload offset of the map entry that a map address selects
    function automatic int map_off(input logic [7:0] a);
        map_off = MCSQ_OFF_DROPMAP + int'(a[7:2] - MCSQ_REG_MAP[7:2]);
    endfunction

    // any address that holds a register
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == MCSQ_REG_CTRL) || (a == MCSQ_REG_STATUS) || (a == MCSQ_REG_IRQ_ST)
              || (a == MCSQ_REG_IRQ_MSK) || in_map(a)
              || (a[1:0] == 2'b00 && a >= MCSQ_REG_CFG0 && a <= MCSQ_REG_CFG3);
    endfunction

    // clamp an enumerated code into its legal range
    function automatic logic [7:0] lim(input logic [7:0] v, input logic [7:0] mx);
        lim = (v > mx) ? mx : v;
    endfunction

    function automatic logic [7:0] vol(input logic [7:0] v);
        if ($signed(v) < MCSQ_VOL_MIN)
            vol = MCSQ_VOL_MIN;
        else if ($signed(v) > MCSQ_VOL_MAX)
            vol = MCSQ_VOL_MAX;
        else
            vol = v;
    endfunction

    assign pslverr = psel && penable && !mapped(paddr);

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable <= 1'b0;
        else if (wr && paddr == MCSQ_REG_CTRL)
            enable <= pwdata[0];
    end

    // configuration store; each write lands at its payload offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < MCSQ_PAYLOAD_LEN; i++)
                cfg[i] <= MCSQ_RST_BYTE;
            // masks leave reset allowing every alarm
            cfg[MCSQ_OFF_TXMASK1]  <= MCSQ_RST_MASK;
            cfg[MCSQ_OFF_TXMASK2]  <= MCSQ_RST_MASK & MCSQ_TXMASK2_USED;
            cfg[MCSQ_OFF_CMNMASK2] <= MCSQ_RST_MASK & MCSQ_CMN2_USED;
        end
        else if (wr)
        begin
            unique case (paddr)
                MCSQ_REG_CFG0:
                begin
                    cfg[MCSQ_OFF_SPECTRUM] <= lim(pwdata[7:0], MCSQ_MAX_BOOL);
                    cfg[MCSQ_OFF_OPMODE]   <= lim(pwdata[15:8], MCSQ_MAX_BOOL);
                    cfg[MCSQ_OFF_CLKSRC]   <= lim(pwdata[23:16], MCSQ_MAX_CLKSRC);
                    cfg[MCSQ_OFF_CLKPOL]   <= lim(pwdata[31:24], MCSQ_MAX_CLKPOL);
                end
                MCSQ_REG_CFG1:
                begin
                    cfg[MCSQ_OFF_SENDTIM]  <= lim(pwdata[7:0], MCSQ_MAX_BOOL);
                    cfg[MCSQ_OFF_FRAMING]  <= lim(pwdata[15:8], MCSQ_MAX_FRAMING);
                    cfg[MCSQ_OFF_DROPMODE] <= lim(pwdata[23:16], MCSQ_MAX_DROPMODE);
                    cfg[MCSQ_OFF_YELSEL]   <= lim(pwdata[31:24], MCSQ_MAX_BOOL);
                end
                MCSQ_REG_CFG2:
                begin
                    cfg[MCSQ_OFF_FORCED]   <= pwdata[7:0] & MCSQ_FORCED_USED;
                    cfg[MCSQ_OFF_TXMASK1]  <= pwdata[15:8];
                    cfg[MCSQ_OFF_TXMASK2]  <= pwdata[23:16] & MCSQ_TXMASK2_USED;
                    cfg[MCSQ_OFF_CMNMASK2] <= pwdata[31:24] & MCSQ_CMN2_USED;
                end
                MCSQ_REG_CFG3:
                begin
                    cfg[MCSQ_OFF_SVC1_VOL] <= vol(pwdata[7:0]);
                    cfg[MCSQ_OFF_SVC2_VOL] <= vol(pwdata[15:8]);
                    cfg[MCSQ_OFF_IFTYPE]   <= lim(pwdata[23:16], MCSQ_MAX_IFTYPE);
                    cfg[MCSQ_OFF_TERR_LB]  <= pwdata[24] ? 8'h01 : 8'h00;
                    cfg[MCSQ_OFF_BB_LB]    <= pwdata[25] ? 8'h01 : 8'h00;
                end
                default:
                begin
                    if (in_map(paddr))
                        cfg[map_off(paddr)] <= pwdata[7:0];
                end
            endcase
        end
    end

    // query recogniser and serialiser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= MCSQ_IDLE;
            op_hi <= 8'h00;
            idx   <= 6'h00;
        end
        else
        begin
            unique case (state)
                MCSQ_IDLE:
                    if (cmd_in.valid && enable)
                    begin
                        op_hi <= cmd_in.data;
                        state <= MCSQ_OPLO;
                    end
                MCSQ_OPLO:
                    if (cmd_in.valid)
                    begin
                        idx   <= 6'h00;
                        state <= ({op_hi, cmd_in.data} == MCSQ_OPCODE_QUERY)
                               ? MCSQ_SEND : MCSQ_IDLE;
                    end
                MCSQ_SEND:
                    if (rsp_ready)
                    begin
                        if (idx == 6'(MCSQ_PAYLOAD_LEN - 1))
                            state <= MCSQ_IDLE;
                        idx <= idx + 6'h01;
                    end
            endcase
        end
    end

    assign ev_query = state == MCSQ_OPLO && cmd_in.valid
                   && {op_hi, cmd_in.data} == MCSQ_OPCODE_QUERY;
    assign ev_bad   = state == MCSQ_OPLO && cmd_in.valid
                   && {op_hi, cmd_in.data} != MCSQ_OPCODE_QUERY;
    assign ev_done  = state == MCSQ_SEND && rsp_ready && idx == 6'(MCSQ_PAYLOAD_LEN - 1);

    // answer byte stream, combinational handshake, registered data
    assign rsp_out.valid = state == MCSQ_SEND;
    assign rsp_out.data  = rsp_byte;
    assign rsp_last      = state == MCSQ_SEND && idx == 6'(MCSQ_PAYLOAD_LEN - 1);

    // answer byte register, loaded one step ahead of the index
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rsp_byte <= 8'h00;
        else if (ev_query)
            rsp_byte <= cfg[MCSQ_OFF_SPECTRUM];
        else if (state == MCSQ_SEND && rsp_ready && !rsp_last)
            rsp_byte <= cfg[idx + 6'h01];
        else if (ev_done)
            rsp_byte <= 8'h00;
    end

    // sticky events, set wins; a read clears only the bits it returned
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_st <= '0;
        else
            irq_st <= (irq_st & ~((rd && paddr == MCSQ_REG_IRQ_ST)
                                  ? prdata[MCSQ_IRQ_W-1:0] : '0))
                    | {ev_bad, ev_done, ev_query};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_msk <= '0;
        else if (wr && paddr == MCSQ_REG_IRQ_MSK)
            irq_msk <= pwdata[MCSQ_IRQ_W-1:0];
    end

    assign irq = |(irq_st & irq_msk);

    // read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                MCSQ_REG_CTRL:    prdata <= {31'h0, enable};
                MCSQ_REG_STATUS:  prdata <= {24'h0, idx, 2'(state)};
                MCSQ_REG_IRQ_ST:  prdata <= {29'h0, irq_st};
                MCSQ_REG_IRQ_MSK: prdata <= {29'h0, irq_msk};
                MCSQ_REG_CFG0:    prdata <= {cfg[MCSQ_OFF_CLKPOL], cfg[MCSQ_OFF_CLKSRC],
                                             cfg[MCSQ_OFF_OPMODE], cfg[MCSQ_OFF_SPECTRUM]};
                MCSQ_REG_CFG1:    prdata <= {cfg[MCSQ_OFF_YELSEL], cfg[MCSQ_OFF_DROPMODE],
                                             cfg[MCSQ_OFF_FRAMING], cfg[MCSQ_OFF_SENDTIM]};
                MCSQ_REG_CFG2:    prdata <= {cfg[MCSQ_OFF_CMNMASK2], cfg[MCSQ_OFF_TXMASK2],
                                             cfg[MCSQ_OFF_TXMASK1], cfg[MCSQ_OFF_FORCED]};
                MCSQ_REG_CFG3:    prdata <= {6'h0, cfg[MCSQ_OFF_BB_LB][0],
                                             cfg[MCSQ_OFF_TERR_LB][0], cfg[MCSQ_OFF_IFTYPE],
                                             cfg[MCSQ_OFF_SVC2_VOL], cfg[MCSQ_OFF_SVC1_VOL]};
                default:
                begin
                    if (in_map(paddr))
                        prdata <= {24'h0, cfg[map_off(paddr)]};
                    else
                        prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    AST_QUERY_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
        ev_query |=> rsp_out.valid && idx == 6'h00)
        else $error("query did not start answer");
    AST_BAD_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        ev_bad |=> !rsp_out.valid)
        else $error("wrong opcode answered");
    AST_SPECTRUM_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_SPECTRUM) |-> rsp_out.data <= MCSQ_MAX_BOOL)
        else $error("spectrum code out of range");
    AST_OPMODE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_OPMODE) |-> rsp_out.data <= MCSQ_MAX_BOOL)
        else $error("mode code out of range");
    AST_CLKSRC_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_CLKSRC) |-> rsp_out.data <= MCSQ_MAX_CLKSRC)
        else $error("clock source out of range");
    AST_FRAMING_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_FRAMING) |-> rsp_out.data <= MCSQ_MAX_FRAMING)
        else $error("framing out of range");
    AST_FORCED_SPARE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_FORCED) |-> rsp_out.data[7:6] == 2'b00)
        else $error("forced spare bits set");
    AST_VOL_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_SVC1_VOL) |->
        $signed(rsp_out.data) >= MCSQ_VOL_MIN && $signed(rsp_out.data) <= MCSQ_VOL_MAX)
        else $error("volume out of range");
    AST_IDX_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && rsp_ready && !rsp_last |=> rsp_out.valid && idx == $past(idx) + 6'h01)
        else $error("payload byte skipped");
    AST_IDX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && !rsp_ready |=> $stable(idx) && rsp_out.valid)
        else $error("byte lost under stall");
    AST_LAST_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_last && rsp_ready |=> !rsp_out.valid ##1 !rsp_out.valid)
        else $error("answer ran past end");

    COV_QUERY: cover property (@(posedge pclk) disable iff (!presetn) ev_query);
    COV_DONE: cover property (@(posedge pclk) disable iff (!presetn) ev_done);
    COV_BAD: cover property (@(posedge pclk) disable iff (!presetn) ev_bad);
    COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    COV_STALL: cover property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && !rsp_ready);

    // remaining answer fields stay inside their code ranges
    AST_CLKPOL_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_CLKPOL) |-> rsp_out.data <= MCSQ_MAX_CLKPOL)
        else $error("clock polarity out of range");
    AST_SENDTIM_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_SENDTIM) |-> rsp_out.data <= MCSQ_MAX_BOOL)
        else $error("send timing out of range");
    AST_DROPMODE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_DROPMODE) |-> rsp_out.data <= MCSQ_MAX_DROPMODE)
        else $error("drop mode out of range");
    AST_YELSEL_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_YELSEL) |-> rsp_out.data <= MCSQ_MAX_BOOL)
        else $error("yellow select out of range");
    AST_TXMASK2_SPARE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_TXMASK2) |->
        (rsp_out.data & ~MCSQ_TXMASK2_USED) == 8'h00)
        else $error("transmit mask spare bits set");
    AST_CMNMASK2_SPARE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_CMNMASK2) |->
        (rsp_out.data & ~MCSQ_CMN2_USED) == 8'h00)
        else $error("common mask spare bits set");
    AST_VOL2_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_SVC2_VOL) |->
        $signed(rsp_out.data) >= MCSQ_VOL_MIN && $signed(rsp_out.data) <= MCSQ_VOL_MAX)
        else $error("second volume out of range");
    AST_IFTYPE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_IFTYPE) |-> rsp_out.data <= MCSQ_MAX_IFTYPE)
        else $error("interface type out of range");
    AST_TERR_LB_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_TERR_LB) |-> rsp_out.data <= MCSQ_MAX_BOOL)
        else $error("terrestrial loopback out of range");
    AST_BB_LB_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && idx == 6'(MCSQ_OFF_BB_LB) |-> rsp_out.data <= MCSQ_MAX_BOOL)
        else $error("baseband loopback out of range");

    // command sequencing and answer handshake
    AST_DATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        rsp_out.valid && !rsp_ready |=> $stable(rsp_out.data))
        else $error("answer byte changed under stall");
    AST_DISABLED_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !enable && state == MCSQ_IDLE |=> state == MCSQ_IDLE)
        else $error("command taken while disabled");
    AST_SEND_AFTER_QUERY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(rsp_out.valid) |-> $past(ev_query))
        else $error("answer without query");
    AST_OPCODE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        state == MCSQ_OPLO && !cmd_in.valid |=> state == MCSQ_OPLO && op_hi == $past(op_hi))
        else $error("opcode high byte lost");

    // every event lands in its sticky bit, map accesses raise no error, a status read clears what it returned
    AST_QUERY_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        ev_query |=> irq_st[MCSQ_IRQ_QUERY])
        else $error("query event not recorded");
    AST_DONE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        ev_done |=> irq_st[MCSQ_IRQ_DONE])
        else $error("done event not recorded");
    AST_BAD_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        ev_bad |=> irq_st[MCSQ_IRQ_BADOP])
        else $error("bad opcode event not recorded");
    AST_PSLVERR_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && in_map(paddr) |-> !pslverr)
        else $error("error on drop map access");
    AST_CLEAR_ON_READ: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == MCSQ_REG_IRQ_ST && !ev_query && !ev_done && !ev_bad
        |=> (32'(irq_st) & $past(prdata)) == 32'h0000_0000)
        else $error("read bits not cleared");

endmodule

/* modulator_config_status_query_test.sv */
// modulator_config_status_query_test: self-checking bench for the query block
// assumes mcsq_query with apb registers and the mcsq_host link model
`timescale 1ns/1ps
module modulator_config_status_query_test
    import mcsq_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    mcsq_byte_t  cmd;
    mcsq_byte_t  rsp;
    logic        rsp_last;
    logic        rsp_ready;
    logic        irq;
    int          err_total;
    int          cmp_count;
    int          cyc;

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    mcsq_query DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_in(cmd), .rsp_out(rsp), .rsp_last(rsp_last),
        .rsp_ready(rsp_ready), .irq(irq));
    mcsq_host host (.pclk(pclk), .cmd_out(cmd), .rsp_in(rsp), .rsp_last(rsp_last),
        .rsp_ready(rsp_ready));

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, 32'h0000_0000);
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rchk(MCSQ_REG_CFG2, 32'h073F_FF00);
        rchk(MCSQ_REG_CFG0, 32'h0000_0000);
        rchk(MCSQ_REG_IRQ_MSK, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        rchk(MCSQ_REG_STATUS, 32'h0000_0000);
        host.run(MCSQ_OPCODE_QUERY, 1'b0, 10);
        chk(32'(host.n_got), 32'h0000_0000);
        rchk(MCSQ_REG_IRQ_ST, 32'h0000_0000);
        $display("reset and unmapped test done");
    endtask

    // program the store, query it and compare every answer byte
    task automatic t_query(input logic [31:0] c0, c1, c2, c3, e0, e1, e2, e3, input bit slow);
        logic [7:0] exp [0:MCSQ_PAYLOAD_LEN-1];
        wreg(MCSQ_REG_CFG0, c0);
        wreg(MCSQ_REG_CFG1, c1);
        wreg(MCSQ_REG_CFG2, c2);
        wreg(MCSQ_REG_CFG3, c3);
        for (int i = 0; i < MCSQ_DROPMAP_LEN; i++)
            wreg(MCSQ_REG_MAP + 8'(4 * i), {24'h0, slow, 7'(i + 1)});
        for (int i = 0; i < 4; i++)
        begin
            exp[i] = e0[8*i +: 8];
            exp[MCSQ_OFF_FORCED + i] = e2[8*i +: 8];
        end
        for (int i = 0; i < 3; i++)
        begin
            exp[MCSQ_OFF_SENDTIM + i] = e1[8*i +: 8];
            exp[MCSQ_OFF_SVC1_VOL + i] = e3[8*i +: 8];
        end
        for (int i = 0; i < MCSQ_DROPMAP_LEN; i++)
            exp[MCSQ_OFF_DROPMAP + i] = {slow, 7'(i + 1)};
        exp[MCSQ_OFF_YELSEL]  = e1[31:24];
        exp[MCSQ_OFF_TERR_LB] = {7'h0, e3[24]};
        exp[MCSQ_OFF_BB_LB]   = {7'h0, e3[25]};
        host.run(MCSQ_OPCODE_QUERY, slow, 300);
        chk(32'(host.n_got), 32'(MCSQ_PAYLOAD_LEN));
        chk(32'(host.last_at), 32'(MCSQ_PAYLOAD_LEN - 1));
        for (int i = 0; i < MCSQ_PAYLOAD_LEN; i++)
            chk({24'h0, host.got[i]}, {24'h0, exp[i]});
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0000_0001);
        rchk(MCSQ_REG_IRQ_ST, 32'h0000_0003);
        rchk(MCSQ_REG_IRQ_ST, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("query test done, slow=%0d", slow);
    endtask

    // wrong opcode with its irq bit masked: no answer, status still set
    task automatic t_badop();
        wreg(MCSQ_REG_IRQ_MSK, 32'h0000_0003);
        host.run(16'h2401, 1'b0, 20);
        chk(32'(host.n_got), 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        rchk(MCSQ_REG_IRQ_ST, 32'h0000_0004);
        $display("bad opcode test done");
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            final_report();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        wreg(MCSQ_REG_CTRL, 32'h0000_0001);
        rchk(MCSQ_REG_CTRL, 32'h0000_0001);
        wreg(MCSQ_REG_IRQ_MSK, 32'h0000_0007);
        t_query(32'h0202_0101, 32'h010C_0501, 32'hFFFF_FFFF, 32'h030C_0BE2,
                32'h0202_0101, 32'h0109_0301, 32'h073F_FF3F, 32'h0309_0AEC, 1'b0);
        t_query(32'h0100_0100, 32'h0008_0200, 32'h0005_2A15, 32'h0207_0AEC,
                32'h0100_0100, 32'h0008_0200, 32'h0005_2A15, 32'h0207_0AEC, 1'b1);
        t_badop();
        final_report();
    end
endmodule
